// >>> pkg/host_port_pkg.sv
// Shared constants and helpers for the host port physical layer
package host_port_pkg;

    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    localparam int PAGE_W = 8;
    localparam int SYNC_W = 29;

    // Status word layout
    localparam int STAT_PAGE_LSB = 8;
    localparam int STAT_CMD_BIT = 2;
    localparam int STAT_INT_BIT = 1;
    localparam int STAT_WAIT_BIT = 0;
    localparam logic [4:0] STAT_RSVD_VAL = 5'h00;

    // Reset values
    localparam logic [15:0] WORD_RESET = 16'h0000;
    // Strobes, chip select and slave select idle high
    localparam logic [28:0] SYNC_RESET = 29'h00001640;

    // Serial bit counter marks
    localparam logic [3:0] SPI_LAST_BIT = 4'hf;
    localparam logic [3:0] SPI_HALF = 4'h8;
    localparam logic [3:0] SPI_ZERO = 4'h0;

    // Access type {address select, read}
    typedef enum logic [1:0] {
        ACC_WR_DATA = 2'h0,
        ACC_RD_DATA = 2'h1,
        ACC_WR_CMD = 2'h2,
        ACC_RD_STAT = 2'h3
    } access_t;

    typedef enum logic {
        PH_FIRST = 1'b0,
        PH_SECOND = 1'b1
    } phase_t;

    function automatic logic [15:0] swap_bytes(input logic [15:0] w);
        return {w[7:0], w[15:8]};
    endfunction : swap_bytes

endpackage : host_port_pkg

// >>> src/pin_sync.sv
// Two-stage synchroniser for a vector of pin inputs
`timescale 1ns/100ps
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk_sys_in) begin
                if (rst_in) begin
                    meta_reg[i] <= RESET_VAL[i];
                    sync_reg[i] <= RESET_VAL[i];
                end else begin
                    meta_reg[i] <= async_in[i];
                    sync_reg[i] <= meta_reg[i];
                end
            end
        end
    endgenerate

    assign sync_out = sync_reg;

endmodule : pin_sync

// >>> src/spi_slave_shifter.sv
// Oversampled serial slave shifter with slave-select framing
`timescale 1ns/100ps
module spi_slave_shifter
    import host_port_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic sck_in,
    input wire logic mosi_in,
    input wire logic ss_n_in,
    input wire logic [15:0] tx_word_in,
    output logic [15:0] rx_word_out,
    output logic rx_valid_out,
    output logic frame_reset_out,
    output logic miso_out
);

    logic sck_prev_reg;
    logic ss_prev_reg;
    logic [3:0] cnt_reg;
    logic [15:0] rx_shift_reg;
    logic [15:0] tx_shift_reg;
    logic miso_reg;
    logic [15:0] rx_word_reg;
    logic rx_valid_reg;
    logic frame_reset_reg;
    logic sck_rise;
    logic sck_fall;
    logic ss_rise;
    logic ss_fall;
    logic bad_frame;

    assign sck_rise = sck_in & ~sck_prev_reg & ~ss_n_in;
    assign sck_fall = ~sck_in & sck_prev_reg & ~ss_n_in;
    assign ss_rise = ss_n_in & ~ss_prev_reg;
    assign ss_fall = ~ss_n_in & ss_prev_reg;
    assign bad_frame = ss_rise && cnt_reg != SPI_ZERO && cnt_reg != SPI_HALF;

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            sck_prev_reg <= 1'b0;
            ss_prev_reg <= 1'b1;
        end else begin
            sck_prev_reg <= sck_in;
            ss_prev_reg <= ss_n_in;
        end
    end

    // Receive on rising clock, drop frames ending mid-byte
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            cnt_reg <= SPI_ZERO;
            rx_shift_reg <= WORD_RESET;
            rx_word_reg <= WORD_RESET;
            rx_valid_reg <= 1'b0;
            frame_reset_reg <= 1'b0;
        end else begin
            rx_valid_reg <= 1'b0;
            frame_reset_reg <= bad_frame;
            if (bad_frame) begin
                cnt_reg <= SPI_ZERO;
            end else if (sck_rise) begin
                rx_shift_reg <= {rx_shift_reg[14:0], mosi_in};
                cnt_reg <= cnt_reg + 4'h1;
                if (cnt_reg == SPI_LAST_BIT) begin
                    rx_word_reg <= {rx_shift_reg[14:0], mosi_in};
                    rx_valid_reg <= 1'b1;
                end
            end
        end
    end

    // Transmit on falling clock or select edge
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            tx_shift_reg <= WORD_RESET;
            miso_reg <= 1'b0;
        end else if ((sck_fall || ss_fall) && cnt_reg == SPI_ZERO) begin
            miso_reg <= tx_word_in[15];
            tx_shift_reg <= {tx_word_in[14:0], 1'b0};
        end else if (sck_fall) begin
            miso_reg <= tx_shift_reg[15];
            tx_shift_reg <= {tx_shift_reg[14:0], 1'b0};
        end
    end

    assign rx_word_out = rx_word_reg;
    assign rx_valid_out = rx_valid_reg;
    assign frame_reset_out = frame_reset_reg;
    assign miso_out = miso_reg;

    a_miso_on_fall: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        $changed(miso_reg) |-> $past(sck_fall || ss_fall))
        else $error("serial output changed without falling clock");

    a_rx_on_rise: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        rx_valid_reg |-> $past(sck_rise) && $past(cnt_reg) == SPI_LAST_BIT)
        else $error("serial word completed off a rising edge");

endmodule : spi_slave_shifter

// >>> src/host_port_physical_layer.sv
// Parallel and serial host port front end with command interpreter
`timescale 1ns/100ps
module host_port_physical_layer
    import host_port_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic host_chip_select_n_in,
    input wire logic host_addr_select_in,
    input wire logic host_write_strobe_n_in,
    input wire logic host_read_strobe_n_in,
    input wire logic [15:0] host_data_bus_in,
    output logic [15:0] host_data_bus_out,
    output logic host_data_bus_oe_n_out,
    output logic host_wait_out,
    output logic host_wait_oe_n_out,
    input wire logic cfg_bus_16bit_in,
    input wire logic cfg_combined_strobe_in,
    input wire logic cfg_byte_swap_in,
    input wire logic cfg_wait_enable_in,
    input wire logic cfg_wait_active_high_in,
    input wire logic cfg_wait_drive_in,
    input wire logic spi_sck_in,
    input wire logic spi_mosi_in,
    input wire logic spi_ss_n_in,
    output logic spi_miso_out,
    input wire logic [7:0] active_page_number_in,
    input wire logic command_in_progress_in,
    input wire logic host_interrupt_in,
    input wire logic command_done_in,
    input wire logic rd_not_ready_in,
    input wire logic [15:0] rd_data_in,
    output logic [15:0] word_out,
    output logic command_strobe_out,
    output logic data_strobe_out,
    output logic interp_reset_out,
    output logic rd_taken_out
);

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    logic [SYNC_W-1:0] raw_vec;
    logic [SYNC_W-1:0] sync_vec;
    logic [15:0] data_s;
    logic cs_n_s, addr_s, wr_n_s, rd_n_s;
    logic sck_s, mosi_s, ss_n_s;
    logic bus16_s, comb_s, swap_s, wen_s, whi_s, wdrv_s;

    assign raw_vec = {host_data_bus_in, host_chip_select_n_in, host_addr_select_in,
                      host_write_strobe_n_in, host_read_strobe_n_in,
                      spi_sck_in, spi_mosi_in, spi_ss_n_in,
                      cfg_bus_16bit_in, cfg_combined_strobe_in, cfg_byte_swap_in,
                      cfg_wait_enable_in, cfg_wait_active_high_in, cfg_wait_drive_in};

    pin_sync #(.WIDTH(SYNC_W), .RESET_VAL(SYNC_RESET)) u_sync (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .async_in(raw_vec),
        .sync_out(sync_vec)
    );

    assign {data_s, cs_n_s, addr_s, wr_n_s, rd_n_s, sck_s, mosi_s, ss_n_s,
            bus16_s, comb_s, swap_s, wen_s, whi_s, wdrv_s} = sync_vec;

    // ------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------
    logic host_data_strobe_n;
    logic host_read_not_write;
    logic access_active;
    logic access_is_read;
    access_t access_type;

    // Combined mode reuses the write pin as data strobe
    assign host_data_strobe_n = wr_n_s;
    assign host_read_not_write = rd_n_s;
    assign access_active = ~cs_n_s & (comb_s ? ~host_data_strobe_n
                                             : (~wr_n_s | ~rd_n_s));
    assign access_is_read = comb_s ? host_read_not_write : ~rd_n_s;
    assign access_type = access_t'({addr_s, access_is_read});

    logic act_prev_reg;
    logic cur_addr_reg;
    logic cur_read_reg;
    logic [15:0] cur_data_reg;
    logic finish;
    logic wr_done;
    logic rd_done;

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            act_prev_reg <= 1'b0;
            cur_addr_reg <= 1'b0;
            cur_read_reg <= 1'b0;
            cur_data_reg <= WORD_RESET;
        end else begin
            act_prev_reg <= access_active;
            if (access_active) begin
                cur_addr_reg <= addr_s;
                cur_read_reg <= access_is_read;
                cur_data_reg <= data_s;
            end
        end
    end

    // Write data taken at the trailing strobe edge
    assign finish = act_prev_reg & ~access_active;
    assign wr_done = finish & ~cur_read_reg;
    assign rd_done = finish & cur_read_reg;

    // ------------------------------------------------------------
    // Byte pairing for the narrow bus
    // ------------------------------------------------------------
    phase_t phase_reg;
    logic [7:0] first_byte_reg;
    logic first_addr_reg;
    logic restart;
    logic word_ready;
    logic word_hint;
    logic [15:0] word_val;

    // Address-high byte after a data byte starts a new command
    assign restart = phase_reg == PH_SECOND && cur_addr_reg && !first_addr_reg;

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            phase_reg <= PH_FIRST;
            first_byte_reg <= 8'h00;
            first_addr_reg <= 1'b0;
        end else if (wr_done && !bus16_s) begin
            if (phase_reg == PH_FIRST || restart) begin
                first_byte_reg <= cur_data_reg[7:0];
                first_addr_reg <= cur_addr_reg;
                phase_reg <= PH_SECOND;
            end else begin
                phase_reg <= PH_FIRST;
            end
        end
    end

    always_comb begin
        word_ready = 1'b0;
        word_hint = cur_addr_reg;
        word_val = cur_data_reg;
        if (wr_done) begin
            if (bus16_s) begin
                word_ready = 1'b1;
            end else if (phase_reg == PH_SECOND && !restart) begin
                word_ready = 1'b1;
                word_hint = first_addr_reg;
                word_val = {first_byte_reg, cur_data_reg[7:0]};
            end
        end
    end

    // ------------------------------------------------------------
    // Serial slave
    // ------------------------------------------------------------
    logic [15:0] spi_word;
    logic spi_word_valid;
    logic spi_frame_reset;
    logic [15:0] rd_word;

    assign rd_word = swap_s ? swap_bytes(rd_data_in) : rd_data_in;

    spi_slave_shifter u_spi (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .sck_in(sck_s),
        .mosi_in(mosi_s),
        .ss_n_in(ss_n_s),
        .tx_word_in(rd_word),
        .rx_word_out(spi_word),
        .rx_valid_out(spi_word_valid),
        .frame_reset_out(spi_frame_reset),
        .miso_out(spi_miso_out)
    );

    // ------------------------------------------------------------
    // Command interpreter
    // ------------------------------------------------------------
    logic expect_cmd_reg;
    logic any_word;
    logic src_hint;
    logic take_cmd;
    logic [15:0] src_word;
    logic [15:0] word_reg;
    logic cmd_strobe_reg;
    logic data_strobe_reg;
    logic interp_reset_reg;

    // Parallel word wins if both ports finish together
    assign any_word = word_ready | spi_word_valid;
    assign src_word = word_ready ? word_val : spi_word;
    assign src_hint = word_ready & word_hint;
    assign take_cmd = any_word & (src_hint | expect_cmd_reg);

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            expect_cmd_reg <= 1'b1;
        end else if (command_done_in || spi_frame_reset) begin
            expect_cmd_reg <= 1'b1;
        end else if (take_cmd) begin
            expect_cmd_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            word_reg <= WORD_RESET;
            cmd_strobe_reg <= 1'b0;
            data_strobe_reg <= 1'b0;
            interp_reset_reg <= 1'b0;
        end else begin
            cmd_strobe_reg <= take_cmd;
            data_strobe_reg <= any_word & ~take_cmd;
            interp_reset_reg <= src_hint | spi_frame_reset;
            if (any_word) begin
                // Commands never swapped
                word_reg <= (!take_cmd && swap_s) ? swap_bytes(src_word)
                                                  : src_word;
            end
        end
    end

    // ------------------------------------------------------------
    // Read path and status word
    // ------------------------------------------------------------
    logic [1:0] rd_half_reg;
    logic wait_state_reg;
    logic wait_active;
    logic [15:0] status_word;
    logic [15:0] sel_word;
    logic [15:0] bus_val;
    logic [15:0] bus_out_reg;
    logic bus_oe_n_reg;
    logic rd_taken_reg;

    assign status_word = {active_page_number_in, STAT_RSVD_VAL,
                          command_in_progress_in, host_interrupt_in,
                          wait_state_reg};
    assign sel_word = (access_type == ACC_RD_STAT) ? status_word : rd_word;
    assign bus_val = bus16_s ? sel_word
                   : {8'h00, rd_half_reg[addr_s] ? sel_word[7:0] : sel_word[15:8]};

    // Byte half per access kind; status bytes keep their own phase
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            rd_half_reg <= 2'h0;
        end else begin
            if (rd_done && !bus16_s) begin
                rd_half_reg[cur_addr_reg] <= ~rd_half_reg[cur_addr_reg];
            end else if (take_cmd) begin
                rd_half_reg[0] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            bus_out_reg <= WORD_RESET;
            bus_oe_n_reg <= 1'b1;
            rd_taken_reg <= 1'b0;
        end else begin
            bus_oe_n_reg <= ~(access_active & access_is_read);
            if (access_active && access_is_read) begin
                bus_out_reg <= bus_val;
            end
            rd_taken_reg <= (rd_done && !cur_addr_reg && (bus16_s || rd_half_reg[0]))
                          || (spi_word_valid && !take_cmd && !word_ready);
        end
    end

    // ------------------------------------------------------------
    // Wait output
    // ------------------------------------------------------------
    logic wait_level_reg;
    logic wait_oe_n_reg;

    // Pending read data stretches any read, status included
    assign wait_active = wen_s & ~cs_n_s & rd_not_ready_in
                       & ~(access_active & ~access_is_read);

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            wait_state_reg <= 1'b0;
            wait_level_reg <= 1'b0;
            wait_oe_n_reg <= 1'b1;
        end else begin
            wait_state_reg <= wait_active;
            wait_level_reg <= whi_s ? wait_active : ~wait_active;
            wait_oe_n_reg <= ~wdrv_s;
        end
    end

    assign host_data_bus_out = bus_out_reg;
    assign host_data_bus_oe_n_out = bus_oe_n_reg;
    assign host_wait_out = wait_level_reg;
    assign host_wait_oe_n_out = wait_oe_n_reg;
    assign word_out = word_reg;
    assign command_strobe_out = cmd_strobe_reg;
    assign data_strobe_out = data_strobe_reg;
    assign interp_reset_out = interp_reset_reg;
    assign rd_taken_out = rd_taken_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    sequence status_read_16;
        access_active && access_is_read && addr_s && bus16_s;
    endsequence

    sequence cmd_write_16;
        wr_done && cur_addr_reg && bus16_s;
    endsequence

    a_status_page: assert property (
        status_read_16 |=> host_data_bus_out[15:8] == $past(active_page_number_in)
                           && host_data_bus_out[7:3] == STAT_RSVD_VAL)
        else $error("status read gave wrong page or reserved bits");

    a_status_live: assert property (
        status_read_16 |=> host_data_bus_out[2:0] == {$past(command_in_progress_in),
                           $past(host_interrupt_in), $past(wait_state_reg)})
        else $error("status live bits wrong");

    a_cmd_write_reset: assert property (
        cmd_write_16 |=> command_strobe_out && interp_reset_out ##1 !command_strobe_out)
        else $error("command write did not restart interpreter");

    a_status_quiet: assert property (
        (rd_done && cur_addr_reg && !spi_word_valid && !spi_frame_reset)
        |=> !interp_reset_out && !command_strobe_out && !data_strobe_out)
        else $error("status read disturbed interpreter");

    a_done_then_cmd: assert property (
        (expect_cmd_reg && wr_done && bus16_s && !cur_addr_reg && !command_done_in)
        |=> command_strobe_out && !data_strobe_out)
        else $error("word after completion not taken as command");

    a_no_cs_idle: assert property (
        (cs_n_s [*3] ##0 !$past(spi_word_valid))
        |-> host_data_bus_oe_n_out && !data_strobe_out)
        else $error("bus driven or word taken without chip select");

    a_wait_cause: assert property (
        wait_state_reg |-> $past(rd_not_ready_in) && $past(wen_s))
        else $error("wait asserted without pending read data");

    a_swap_data: assert property (
        (wr_done && bus16_s && !cur_addr_reg && !expect_cmd_reg && swap_s)
        |=> data_strobe_out && word_out == swap_bytes($past(cur_data_reg)))
        else $error("data word not byte swapped");

    a_cmd_big_end: assert property (
        cmd_write_16 |=> word_out == $past(cur_data_reg))
        else $error("command word altered by swap");

endmodule : host_port_physical_layer

// >>> tb/host_model.sv
// Host processor model for the parallel and serial ports
`timescale 1ns/100ps
module host_model (
    input wire logic clk_sys_in,
    input wire logic [15:0] dev_data_in,
    input wire logic dev_oe_n_in,
    input wire logic dev_wait_in,
    output logic cs_n_out,
    output logic addr_out,
    output logic wr_n_out,
    output logic rd_n_out,
    output logic [15:0] data_out,
    output logic sck_out,
    output logic mosi_out,
    output logic ss_n_out
);
    initial begin
        cs_n_out = 1'b1;
        addr_out = 1'b0;
        wr_n_out = 1'b1;
        rd_n_out = 1'b1;
        data_out = 16'h5a5a;
        sck_out = 1'b0;
        mosi_out = 1'b0;
        ss_n_out = 1'b1;
    end

    task automatic host_write_strobe_n(input logic a, input logic [15:0] d, input logic cs_n);
        repeat (2) @(posedge clk_sys_in);
        #1;
        cs_n_out = cs_n;
        addr_out = a;
        data_out = d;
        wr_n_out = 1'b0;
        repeat (4) @(posedge clk_sys_in);
        #1;
        wr_n_out = 1'b1;
        cs_n_out = 1'b1;
        data_out = ~d;
    endtask : host_write_strobe_n

    // Returns {bus enable, wait pin, bus data}
    task automatic host_read_strobe_n(input logic a, output logic [17:0] q);
        repeat (4) @(posedge clk_sys_in);
        #1;
        cs_n_out = 1'b0;
        addr_out = a;
        rd_n_out = 1'b0;
        repeat (5) @(posedge clk_sys_in);
        #1;
        q = {dev_oe_n_in, dev_wait_in, dev_data_in};
        rd_n_out = 1'b1;
        cs_n_out = 1'b1;
    endtask : host_read_strobe_n

    // Clock only runs inside a frame, MSB first
    task automatic spi(input logic [15:0] w);
        integer i;
        @(posedge clk_sys_in);
        #1 ss_n_out = 1'b0;
        for (i = 15; i >= 0; i--) begin
            mosi_out = w[i];
            repeat (4) @(posedge clk_sys_in);
            #1 sck_out = 1'b1;
            repeat (4) @(posedge clk_sys_in);
            #1 sck_out = 1'b0;
        end
        repeat (4) @(posedge clk_sys_in);
        #1 ss_n_out = 1'b1;
        mosi_out = ~w[0];
    endtask : spi
endmodule : host_model

// >>> tb/testbench.sv
// Self-checking bench for the host port front end
`timescale 1ns/100ps
module testbench;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic cfg_bus_16bit_in = 1'b1, cfg_byte_swap_in = 1'b0, cfg_wait_enable_in = 1'b0;
    logic cfg_wait_active_high_in = 1'b1, cfg_wait_drive_in = 1'b0;
    logic [7:0] active_page_number_in = 8'h00;
    logic command_in_progress_in = 1'b0, host_interrupt_in = 1'b0;
    logic command_done_in = 1'b0, rd_not_ready_in = 1'b0;
    logic [15:0] rd_data_in = 16'h0000;
    logic cs_n, addr, wr_n, rd_n, sck, mosi, ss_n, spi_miso_out;
    logic [15:0] hd, host_data_bus_out, word_out;
    logic host_data_bus_oe_n_out, host_wait_out, host_wait_oe_n_out;
    logic command_strobe_out, data_strobe_out, interp_reset_out;
    integer mismatches = 0, cmp_count = 0, seed, i;
    logic [31:0] v;
    logic [17:0] q;
    logic [17:0] obs[$];
    logic [15:0] miso_sh = 16'h0000;
    integer taken = 0;

    always #50 clk_sys_in = ~clk_sys_in;

    host_port_physical_layer host_port_physical_layer_inst (.clk_sys_in, .rst_in,
        .host_chip_select_n_in(cs_n), .host_addr_select_in(addr),
        .host_write_strobe_n_in(wr_n), .host_read_strobe_n_in(rd_n), .host_data_bus_in(hd),
        .host_data_bus_out, .host_data_bus_oe_n_out, .host_wait_out, .host_wait_oe_n_out,
        .cfg_bus_16bit_in, .cfg_combined_strobe_in(1'b0), .cfg_byte_swap_in,
        .cfg_wait_enable_in, .cfg_wait_active_high_in, .cfg_wait_drive_in,
        .spi_sck_in(sck), .spi_mosi_in(mosi), .spi_ss_n_in(ss_n), .spi_miso_out,
        .active_page_number_in, .command_in_progress_in, .host_interrupt_in,
        .command_done_in, .rd_not_ready_in, .rd_data_in, .word_out, .command_strobe_out,
        .data_strobe_out, .interp_reset_out, .rd_taken_out(rd_taken_out));
    logic rd_taken_out;

    host_model host_model_inst (.clk_sys_in, .dev_data_in(host_data_bus_out),
        .dev_oe_n_in(host_data_bus_oe_n_out), .dev_wait_in(host_wait_out),
        .cs_n_out(cs_n), .addr_out(addr), .wr_n_out(wr_n), .rd_n_out(rd_n),
        .data_out(hd), .sck_out(sck), .mosi_out(mosi), .ss_n_out(ss_n));

    // ------------------------------------------------------------
    // Observed queue of taken words {command, restart, word}
    // ------------------------------------------------------------
    // Outputs sampled mid-cycle, away from the launching edge
    always @(negedge clk_sys_in) begin
        if (command_strobe_out | data_strobe_out | interp_reset_out)
            obs.push_back({command_strobe_out, interp_reset_out, word_out});
        if (rd_taken_out === 1'b1)
            taken++;
    end

    // Master samples the serial output on its rising clock
    always @(posedge sck)
        miso_sh = {miso_sh[14:0], spi_miso_out};

    task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic got(output logic [17:0] w);
        integer n;
        for (n = 0; n < 12 && obs.size() == 0; n++) @(posedge clk_sys_in);
        #1 w = (obs.size() != 0) ? obs.pop_front() : 18'bx;
    endtask : got

    task automatic done_pulse;
        @(posedge clk_sys_in);
        #1 command_done_in = 1'b1;
        @(posedge clk_sys_in);
        #1 command_done_in = 1'b0;
    endtask : done_pulse

    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results

    initial begin
        repeat (30000) @(posedge clk_sys_in);
        mismatches++;
        results();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 32'hb2cf6d3f;
        repeat (8) @(posedge clk_sys_in);
        #1 rst_in = 1'b0;
        chk({16'h0, host_wait_oe_n_out, host_data_bus_oe_n_out}, 18'h3);
        for (i = 0; i < 4; i++) begin
            v = $random(seed);
            active_page_number_in = v[7:0];
            command_in_progress_in = v[8];
            host_interrupt_in = v[9];
            host_model_inst.host_read_strobe_n(1'b1, q);
            chk(q, {2'b00, v[7:0], 5'h00, v[8], v[9], 1'b0});
        end
        chk(18'(obs.size()), 18'h0);
        $display("test 1 done");
        v = $random(seed);
        host_model_inst.host_write_strobe_n(1'b1, v[15:0], 1'b0);
        got(q);
        chk(q, {2'b11, v[15:0]});
        host_model_inst.host_read_strobe_n(1'b1, q);
        host_model_inst.host_write_strobe_n(1'b0, v[31:16], 1'b0);
        got(q);
        chk(q, {2'b00, v[31:16]});
        cfg_byte_swap_in = 1'b1;
        host_model_inst.host_write_strobe_n(1'b0, v[15:0], 1'b0);
        got(q);
        chk(q, {2'b00, v[7:0], v[15:8]});
        done_pulse();
        host_model_inst.host_write_strobe_n(1'b0, v[31:16], 1'b0);
        got(q);
        chk(q, {2'b10, v[31:16]});
        host_model_inst.host_write_strobe_n(1'b0, v[15:0], 1'b1);
        repeat (12) @(posedge clk_sys_in);
        chk(18'(obs.size()), 18'h0);
        rd_data_in = v[31:16];
        host_model_inst.host_read_strobe_n(1'b0, q);
        chk(q, {2'b00, v[23:16], v[31:24]});
        $display("test 2 done");
        cfg_wait_enable_in = 1'b1;
        cfg_wait_drive_in = 1'b1;
        rd_not_ready_in = 1'b1;
        host_model_inst.host_read_strobe_n(1'b1, q);
        chk(q, {2'b01, active_page_number_in, 5'h00, command_in_progress_in,
                host_interrupt_in, 1'b1});
        chk({17'h0, host_wait_oe_n_out}, 18'h0);
        cfg_wait_active_high_in = 1'b0;
        host_model_inst.host_read_strobe_n(1'b1, q);
        chk(q[17:16], 2'b00);
        cfg_wait_active_high_in = 1'b1;
        rd_not_ready_in = 1'b0;
        host_model_inst.host_read_strobe_n(1'b1, q);
        chk({q[17:16], 15'h0, q[0]}, 18'h0);
        cfg_wait_enable_in = 1'b0;
        $display("test 3 done");
        cfg_bus_16bit_in = 1'b0;
        v = $random(seed);
        host_model_inst.host_write_strobe_n(1'b1, {8'h00, v[15:8]}, 1'b0);
        host_model_inst.host_write_strobe_n(1'b1, {8'h00, v[7:0]}, 1'b0);
        got(q);
        chk(q, {2'b11, v[15:0]});
        host_model_inst.host_write_strobe_n(1'b0, {8'h00, v[23:16]}, 1'b0);
        host_model_inst.host_write_strobe_n(1'b0, {8'h00, v[31:24]}, 1'b0);
        got(q);
        chk(q, {2'b00, v[31:24], v[23:16]});
        $display("test 4 done");
        cfg_bus_16bit_in = 1'b1;
        cfg_byte_swap_in = 1'b0;
        done_pulse();
        v = $random(seed);
        host_model_inst.spi(v[15:0]);
        got(q);
        chk(q, {2'b10, v[15:0]});
        chk({2'b00, miso_sh}, {2'b00, rd_data_in});
        host_model_inst.spi(v[31:16]);
        got(q);
        chk(q, {2'b00, v[31:16]});
        chk(18'(taken), 18'h2);
        $display("test 5 done");
        results();
    end
endmodule : testbench
